// ===== rtl/fsw_cyc_engine.sv
// Pin cycle engine: one read, write or elevated-voltage pulse per request.
// Assumes flash pins are synchronous; data bus is a three-signal tristate.
`timescale 1ns/10ps
`default_nettype none
module fsw_cyc_engine
  import fsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  fsw_cyc_if.eng cyc,
  output logic [FSW_ADDR_W-1:0] f_addr_nxt,
  output logic f_ce_n_nxt,
  output logic f_oe_n_nxt,
  output logic f_we_n_nxt,
  output logic f_dq_oe_nxt,
  output logic [7:0] f_dq_out_nxt,
  output logic f_hv_en_nxt,
  input wire logic [7:0] f_dq_in
);
  typedef enum logic [1:0] {
    FSW_E_IDLE = 2'b00,
    FSW_E_SETUP = 2'b01,
    FSW_E_ACT = 2'b10,
    FSW_E_HOLD = 2'b11
  } fsw_eng_t;
  fsw_eng_t st_r, st_nxt;
  logic [FSW_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic done_r, done_nxt;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    f_addr_nxt = cyc.addr;
    f_ce_n_nxt = 1'b1;
    f_oe_n_nxt = 1'b1;
    f_we_n_nxt = 1'b1;
    f_dq_oe_nxt = 1'b0;
    f_dq_out_nxt = cyc.wdata;
    f_hv_en_nxt = (cyc.op == FSW_OP_HVPULSE) && (st_r != FSW_E_IDLE);
    case (st_r)
      FSW_E_IDLE: begin
        if (cyc.req) begin
          st_nxt = FSW_E_SETUP;
          cnt_nxt = FSW_CNT_W'(FSW_T_SETUP_CYC);
        end
      end
      FSW_E_SETUP: begin
        // Write strobe low only with output enable high, avoiding inhibit.
        f_ce_n_nxt = 1'b0;
        f_oe_n_nxt = (cyc.op == FSW_OP_READ) ? 1'b0 : 1'b1;
        f_dq_oe_nxt = (cyc.op == FSW_OP_WRITE);
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r <= 1) begin
          st_nxt = FSW_E_ACT;
          case (cyc.op)
            FSW_OP_READ: cnt_nxt = FSW_CNT_W'(FSW_T_ACC_CYC);
            FSW_OP_WRITE: cnt_nxt = FSW_CNT_W'(FSW_T_WP_CYC);
            default: cnt_nxt = FSW_CNT_W'(FSW_T_PROT_CYC);
          endcase
        end
      end
      FSW_E_ACT: begin
        // Strobe width well above the device's glitch filter.
        f_ce_n_nxt = 1'b0;
        f_oe_n_nxt = (cyc.op == FSW_OP_READ) ? 1'b0 : 1'b1;
        f_we_n_nxt = (cyc.op == FSW_OP_READ);
        f_dq_oe_nxt = (cyc.op == FSW_OP_WRITE);
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r <= 1) begin
          st_nxt = FSW_E_HOLD;
          rd_nxt = f_dq_in;
        end
      end
      FSW_E_HOLD: begin
        // Chip select outlasts the strobe so the flash latches on a clean write strobe rise.
        f_ce_n_nxt = 1'b0;
        f_dq_oe_nxt = (cyc.op == FSW_OP_WRITE);
        st_nxt = FSW_E_IDLE;
        done_nxt = 1'b1;
      end
      default: st_nxt = FSW_E_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= FSW_E_IDLE;
      cnt_r <= '0;
      rd_r <= 8'h00;
      done_r <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end
  end
  assign cyc.done = done_r;
  assign cyc.rdata = rd_r;
endmodule
`default_nettype wire

// ===== rtl/fsw_cyc_if.sv
// Interface between the sequencer and the pin cycle engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface fsw_cyc_if;
  import fsw_pkg::*;
  logic req;
  fsw_op_t op;
  logic [FSW_ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic protect_sel;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output op, output addr, output wdata, output protect_sel,
    input done, input rdata);
  modport eng (input req, input op, input addr, input wdata, input protect_sel,
    output done, output rdata);
endinterface
`default_nettype wire

// ===== rtl/fsw_host_ctrl.sv
// Host controller for a parallel flash: APB registers, pin cycles, toggle polling,
// whole-chip protect and unprotect with an elevated voltage enable.
// Assumes an external switch drives the elevated voltage when f_hv_en is high.
`timescale 1ns/10ps
`default_nettype none
module fsw_host_ctrl
  import fsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [FSW_ADDR_W-1:0] f_addr,
  output logic f_ce_n,
  output logic f_oe_n,
  output logic f_we_n,
  output logic [7:0] f_dq_out,
  output logic f_dq_oe,
  input wire logic [7:0] f_dq_in,
  output logic f_hv_en
);
  typedef enum logic [2:0] {
    FSW_S_IDLE = 3'b000,
    FSW_S_SINGLE = 3'b001,
    FSW_S_POLL = 3'b010,
    FSW_S_RESET = 3'b011,
    FSW_S_HV = 3'b100,
    FSW_S_VERIFY = 3'b101
  } fsw_state_t;

  fsw_cyc_if cyc ();
  logic [FSW_ADDR_W-1:0] e_addr;
  logic e_ce_n, e_oe_n, e_we_n, e_dq_oe, e_hv_en;
  logic [7:0] e_dq_out;
  logic cmp_pair, cmp_tog;

  fsw_state_t st_r, st_nxt;
  logic [FSW_ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, fail_r, fail_nxt;
  logic rreq_r, rreq_nxt, win_r, win_nxt, recheck_r, recheck_nxt;
  logic req_r, req_nxt;
  fsw_op_t op_r, op_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, cmp_restart, cmp_sample;
  logic wr_acc, rd_acc, known;

  fsw_cyc_engine i_fsw_cyc_engine (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .cyc(cyc.eng),
    .f_addr_nxt(e_addr),
    .f_ce_n_nxt(e_ce_n),
    .f_oe_n_nxt(e_oe_n),
    .f_we_n_nxt(e_we_n),
    .f_dq_oe_nxt(e_dq_oe),
    .f_dq_out_nxt(e_dq_out),
    .f_hv_en_nxt(e_hv_en),
    .f_dq_in(f_dq_in)
  );

  fsw_toggle_cmp i_fsw_toggle_cmp (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .restart(cmp_restart),
    .sample(cmp_sample),
    .data(cyc.rdata),
    .have_pair(cmp_pair),
    .toggling(cmp_tog)
  );

  assign cyc.req = req_r;
  assign cyc.op = op_r;
  assign cyc.addr = addr_r;
  assign cyc.wdata = wdat_r;
  assign cyc.protect_sel = addr_r[FSW_PROT_SEL];

  // APB: answers in the access cycle after one wait state.
  assign wr_acc = psel && penable && pwrite && !pready;
  assign rd_acc = psel && penable && !pwrite && !pready;
  assign known = (paddr == FSW_REG_CTRL) || (paddr == FSW_REG_ADDR)
    || (paddr == FSW_REG_DATA) || (paddr == FSW_REG_STAT) || (paddr == FSW_REG_RDAT);

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pready_nxt = psel && penable && !pready;
    pslverr_nxt = psel && penable && !pready && !known;
    if (rd_acc) begin
      case (paddr)
        FSW_REG_ADDR: prdata_nxt = {{(32 - FSW_ADDR_W){1'b0}}, addr_r};
        FSW_REG_DATA: prdata_nxt = {24'h000000, wdat_r};
        FSW_REG_STAT: begin
          prdata_nxt[FSW_ST_BUSY] = busy_r;
          prdata_nxt[FSW_ST_DONE] = done_r;
          prdata_nxt[FSW_ST_FAIL] = fail_r;
          prdata_nxt[FSW_ST_RESET_REQ] = rreq_r;
          prdata_nxt[FSW_ST_WINDOW] = win_r;
        end
        FSW_REG_RDAT: prdata_nxt = {24'h000000, rdat_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    rreq_nxt = rreq_r;
    win_nxt = win_r;
    recheck_nxt = recheck_r;
    req_nxt = 1'b0;
    op_nxt = op_r;
    cmp_restart = 1'b0;
    cmp_sample = 1'b0;
    if (wr_acc && !busy_r) begin
      if (paddr == FSW_REG_ADDR) addr_nxt = pwdata[FSW_ADDR_W-1:0];
      if (paddr == FSW_REG_DATA) wdat_nxt = pwdata[7:0];
    end
    case (st_r)
      FSW_S_IDLE: begin
        if (wr_acc && paddr == FSW_REG_CTRL) begin
          busy_nxt = 1'b1;
          done_nxt = 1'b0;
          req_nxt = 1'b1;
          op_nxt = FSW_OP_READ;
          case (pwdata[FSW_CMD_LSB +: FSW_CMD_W])
            FSW_CMD_WRITE: begin
              // Holding off new writes after a failure until reset.
              if (rreq_r) begin
                busy_nxt = 1'b0;
                req_nxt = 1'b0;
              end else begin
                op_nxt = FSW_OP_WRITE;
                st_nxt = FSW_S_SINGLE;
              end
            end
            FSW_CMD_POLL: begin
              // Each poll starts from a fresh pair of reads.
              cmp_restart = 1'b1;
              recheck_nxt = 1'b0;
              fail_nxt = 1'b0;
              st_nxt = FSW_S_POLL;
            end
            FSW_CMD_PROT, FSW_CMD_UNPROT: begin
              // Protect-select low protects, high unprotects.
              addr_nxt[FSW_PROT_SEL] = (pwdata[FSW_CMD_LSB +: FSW_CMD_W] == FSW_CMD_UNPROT);
              op_nxt = FSW_OP_HVPULSE;
              st_nxt = FSW_S_HV;
            end
            FSW_CMD_VERIFY: begin
              addr_nxt[FSW_ID_SEL] = 1'b1;
              st_nxt = FSW_S_VERIFY;
            end
            FSW_CMD_READ: st_nxt = FSW_S_SINGLE;
            default: begin
              busy_nxt = 1'b0;
              req_nxt = 1'b0;
            end
          endcase
        end
      end
      FSW_S_SINGLE, FSW_S_HV, FSW_S_VERIFY: begin
        if (cyc.done) begin
          rdat_nxt = cyc.rdata;
          win_nxt = cyc.rdata[FSW_BIT_WINDOW];
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          st_nxt = FSW_S_IDLE;
        end
      end
      FSW_S_POLL: begin
        if (cyc.done) begin
          cmp_sample = 1'b1;
          rdat_nxt = cyc.rdata;
          win_nxt = cyc.rdata[FSW_BIT_WINDOW];
          req_nxt = 1'b1;
          if (cmp_pair && !cmp_tog) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            req_nxt = 1'b0;
            st_nxt = FSW_S_IDLE;
          end else if (cmp_pair && recheck_r) begin
            // Still toggling after the flag rose: failed, restore array reads.
            fail_nxt = 1'b1;
            rreq_nxt = 1'b1;
            op_nxt = FSW_OP_WRITE;
            wdat_nxt = FSW_CMD_RESET;
            st_nxt = FSW_S_RESET;
          end else if (cmp_pair && cyc.rdata[FSW_BIT_TLIMIT]) begin
            recheck_nxt = 1'b1;
          end
        end
      end
      FSW_S_RESET: begin
        if (cyc.done) begin
          rreq_nxt = 1'b0;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          st_nxt = FSW_S_IDLE;
        end
      end
      default: st_nxt = FSW_S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= FSW_S_IDLE;
      addr_r <= '0;
      wdat_r <= 8'h00;
      rdat_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      rreq_r <= 1'b0;
      win_r <= 1'b0;
      recheck_r <= 1'b0;
      req_r <= 1'b0;
      op_r <= FSW_OP_READ;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      f_addr <= '0;
      f_ce_n <= 1'b1;
      f_oe_n <= 1'b1;
      f_we_n <= 1'b1;
      f_dq_out <= 8'h00;
      f_dq_oe <= 1'b0;
      f_hv_en <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rdat_r <= rdat_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      rreq_r <= rreq_nxt;
      win_r <= win_nxt;
      recheck_r <= recheck_nxt;
      req_r <= req_nxt;
      op_r <= op_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      f_addr <= e_addr;
      f_ce_n <= e_ce_n;
      f_oe_n <= e_oe_n;
      f_we_n <= e_we_n;
      f_dq_out <= e_dq_out;
      f_dq_oe <= e_dq_oe;
      f_hv_en <= e_hv_en;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/fsw_pkg.sv
// Package for the flash status poller and protection controller.
// Assumes a byte-wide parallel flash driven by a 50 MHz host controller.
package fsw_pkg;
  localparam int unsigned FSW_CLK_MHZ = 50;
  localparam int unsigned FSW_CLK_NS = 20;
  // Pin timing in ns, converted to cycles with round up for minimums.
  localparam int unsigned FSW_T_ACC_NS = 120;
  localparam int unsigned FSW_T_WP_NS = 60;
  localparam int unsigned FSW_T_SETUP_NS = 40;
  localparam int unsigned FSW_T_ACC_CYC = (FSW_T_ACC_NS + FSW_CLK_NS - 1) / FSW_CLK_NS;
  localparam int unsigned FSW_T_WP_CYC = (FSW_T_WP_NS + FSW_CLK_NS - 1) / FSW_CLK_NS;
  localparam int unsigned FSW_T_SETUP_CYC = (FSW_T_SETUP_NS + FSW_CLK_NS - 1) / FSW_CLK_NS;
  // Protect pulse width in us.
  localparam int unsigned FSW_T_PROT_US = 100;
  localparam int unsigned FSW_T_PROT_CYC = FSW_T_PROT_US * FSW_CLK_MHZ;
  localparam int unsigned FSW_CNT_W = 16;

  // Register word offsets (byte addresses).
  localparam logic [7:0] FSW_REG_CTRL = 8'h00;
  localparam logic [7:0] FSW_REG_ADDR = 8'h04;
  localparam logic [7:0] FSW_REG_DATA = 8'h08;
  localparam logic [7:0] FSW_REG_STAT = 8'h0c;
  localparam logic [7:0] FSW_REG_RDAT = 8'h10;

  // Control register command field.
  localparam int unsigned FSW_CMD_LSB = 0;
  localparam int unsigned FSW_CMD_W = 3;
  localparam logic [2:0] FSW_CMD_READ = 3'h1;
  localparam logic [2:0] FSW_CMD_WRITE = 3'h2;
  localparam logic [2:0] FSW_CMD_POLL = 3'h3;
  localparam logic [2:0] FSW_CMD_PROT = 3'h4;
  localparam logic [2:0] FSW_CMD_UNPROT = 3'h5;
  localparam logic [2:0] FSW_CMD_VERIFY = 3'h6;

  // Status register bits.
  localparam int unsigned FSW_ST_BUSY = 0;
  localparam int unsigned FSW_ST_DONE = 1;
  localparam int unsigned FSW_ST_FAIL = 2;
  localparam int unsigned FSW_ST_RESET_REQ = 3;
  localparam int unsigned FSW_ST_WINDOW = 4;

  // Flash data bit positions, address width and address bit positions.
  localparam int unsigned FSW_BIT_ZERO = 0;
  localparam int unsigned FSW_BIT_WINDOW = 3;
  localparam int unsigned FSW_BIT_TLIMIT = 5;
  localparam int unsigned FSW_BIT_OPTOG = 6;
  localparam int unsigned FSW_ADDR_W = 18;
  localparam int unsigned FSW_ID_SEL = 1;
  localparam int unsigned FSW_PROT_SEL = 6;
  localparam int unsigned FSW_HV_PIN = 9;

  localparam logic [7:0] FSW_CMD_RESET = 8'hf0;

  typedef enum logic [1:0] {
    FSW_OP_READ = 2'b00,
    FSW_OP_WRITE = 2'b01,
    FSW_OP_HVPULSE = 2'b10
  } fsw_op_t;
endpackage

// ===== rtl/fsw_toggle_cmp.sv
// Compares bit FSW_BIT_OPTOG of two consecutive status bytes for toggling.
// Assumes the caller presents each byte with a one-cycle strobe.
`timescale 1ns/10ps
`default_nettype none
module fsw_toggle_cmp
  import fsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic restart,
  input wire logic sample,
  input wire logic [7:0] data,
  output logic have_pair,
  output logic toggling
);
  logic [7:0] prev_r, prev_nxt;
  logic have_r, have_nxt;
  always_comb begin
    prev_nxt = prev_r;
    have_nxt = have_r;
    if (restart) begin
      have_nxt = 1'b0;
    end else if (sample) begin
      prev_nxt = data;
      have_nxt = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 8'h00;
      have_r <= 1'b0;
    end else if (clk_en) begin
      prev_r <= prev_nxt;
      have_r <= have_nxt;
    end
  end
  assign have_pair = have_r;
  assign toggling = prev_r[FSW_BIT_OPTOG] ^ data[FSW_BIT_OPTOG];
endmodule
`default_nettype wire

// ===== verif/fsw_flash_model.sv
// Behavioural byte-wide flash: array, toggle status, time-limit lock-up, protection.
// Assumes pins are sampled on the controller clock; bus_in is the resolved data wire.
`timescale 1ns/10ps
`default_nettype none
module fsw_flash_model
  import fsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [FSW_ADDR_W-1:0] f_addr,
  input wire logic f_ce_n,
  input wire logic f_oe_n,
  input wire logic f_we_n,
  input wire logic f_hv_en,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out
);
  logic [7:0] mem_r [16];
  logic [7:0] rd_r;
  logic [7:0] last_r;
  logic oe_n_r, we_n_r, stuck_r, prot_r, id_r, tog_r;
  int busy_r;
  logic [3:0] sel_r;
  logic ers_r, t2_r;
  int tmo_r;
  localparam int FSW_ERS_WIN = 600;
  // A released bus shows the inverse of the last byte, so a stale sample cannot match.
  assign bus_out = (!f_oe_n && !f_ce_n) ? rd_r : ~rd_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) mem_r[i] <= 8'hff;
      {oe_n_r, we_n_r} <= 2'h3;
      {stuck_r, prot_r, id_r, tog_r} <= 4'h0;
      {ers_r, t2_r} <= 2'h0;
      sel_r <= 4'h0;
      tmo_r <= 0;
      busy_r <= 0;
      rd_r <= 8'h00;
      last_r <= 8'h00;
    end else begin
      oe_n_r <= f_oe_n;
      we_n_r <= f_we_n;
      if (tmo_r == 1) begin
        ers_r <= 1'b1;
        busy_r <= 3;
      end
      if (tmo_r != 0) tmo_r <= tmo_r - 1;
      if (oe_n_r && !f_oe_n && !f_ce_n) begin
        if ((f_hv_en || id_r) && f_addr[FSW_ID_SEL]) begin
          rd_r <= {7'h00, prot_r};
        end else if (stuck_r || busy_r != 0 || tmo_r != 0 || ers_r) begin
          rd_r <= {1'b0, tog_r, stuck_r, 1'b0, ers_r, sel_r[f_addr[3:2]] & t2_r, 2'h0};
          tog_r <= ~tog_r;
          if (sel_r[f_addr[3:2]]) t2_r <= ~t2_r;
          if (!stuck_r && busy_r != 0) busy_r <= busy_r - 1;
          if (ers_r && busy_r == 1) begin
            ers_r <= 1'b0;
            sel_r <= 4'h0;
            for (int i = 0; i < 16; i++) begin
              if (sel_r[i >> 2]) mem_r[i] <= 8'hff;
            end
          end
        end else begin
          rd_r <= mem_r[f_addr[3:0]];
        end
      end
      // Strobes are seen only at clock edges, so a glitch inside a cycle is never taken.
      if (!we_n_r && f_we_n && !f_ce_n) begin
        if (f_hv_en) begin
          prot_r <= ~f_addr[FSW_PROT_SEL];
        end else if (f_oe_n && !ers_r) begin
          last_r <= bus_in;
          if (tmo_r != 0) begin
            if (bus_in == 8'h30) begin
              sel_r[f_addr[3:2]] <= 1'b1;
              tmo_r <= FSW_ERS_WIN;
            end else if (bus_in != 8'hb0) begin
              tmo_r <= 0;
              sel_r <= 4'h0;
            end
          end else if (bus_in == FSW_CMD_RESET) begin
            stuck_r <= 1'b0;
            id_r <= 1'b0;
          end else if (!stuck_r && busy_r == 0) begin
            if (last_r == 8'ha0 && !prot_r) begin
              if (mem_r[f_addr[3:0]] != 8'hff) stuck_r <= 1'b1;
              else begin
                mem_r[f_addr[3:0]] <= bus_in;
                busy_r <= 3;
              end
            end else if (last_r == 8'h80 && bus_in == 8'h30 && !prot_r) begin
              sel_r[f_addr[3:2]] <= 1'b1;
              tmo_r <= FSW_ERS_WIN;
            end else if (bus_in == 8'h90) begin
              id_r <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/fsw_host_ctrl_properties.sv
// Checker for the flash host controller: APB handshake and flash pin relations.
// Assumes it is bound to every instance of the controller and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fsw_host_ctrl_properties
  import fsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [FSW_ADDR_W-1:0] f_addr,
  input wire logic f_ce_n,
  input wire logic f_oe_n,
  input wire logic f_we_n,
  input wire logic f_dq_oe,
  input wire logic [7:0] f_dq_out,
  input wire logic f_hv_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_strobe_low;
    !f_we_n [*3];
  endsequence
  sequence s_prot_held;
    (f_hv_en && !f_ce_n) [*8];
  endsequence
  a_apb_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_write_inhibit: assert property (!f_we_n |-> !f_ce_n && (f_oe_n || f_hv_en))
    else $error("write strobe without chip select or with output enable");
  a_ce_setup: assert property ($fell(f_we_n) && !f_hv_en |-> !$past(f_ce_n, 2))
    else $error("chip select setup too short");
  a_strobe_width: assert property ($fell(f_we_n) |-> s_strobe_low)
    else $error("write strobe too short");
  a_wdata_stable: assert property (!f_we_n && !$past(f_we_n) && !f_hv_en
    |-> f_dq_oe && $stable(f_dq_out))
    else $error("write data not held during strobe");
  a_read_no_drive: assert property (!f_oe_n && !f_hv_en |-> !f_dq_oe)
    else $error("bus driven during read");
  a_prot_pulse: assert property ($fell(f_we_n) && f_hv_en |-> s_prot_held)
    else $error("elevated voltage or chip select dropped in pulse");
  a_prot_addr: assert property (f_hv_en && !f_we_n && !$past(f_we_n)
    |-> $stable(f_addr[FSW_PROT_SEL]))
    else $error("protect select moved during pulse");
endmodule
bind fsw_host_ctrl fsw_host_ctrl_properties i_fsw_host_ctrl_properties (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .f_addr, .f_ce_n, .f_oe_n, .f_we_n, .f_dq_oe,
  .f_dq_out, .f_hv_en);
`default_nettype wire

// ===== verif/fsw_host_ctrl_tb_top.sv
// Testbench for the flash host controller: APB tasks driving flash operations.
// Assumes the flash model answers on the resolved data wire.
`timescale 1ns/10ps
`default_nettype none
module fsw_host_ctrl_tb_top;
  import fsw_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v, u, w;
  logic [FSW_ADDR_W-1:0] f_addr;
  logic f_ce_n, f_oe_n, f_we_n, f_dq_oe, f_hv_en, e;
  logic [7:0] f_dq_out, f_dq_in, model_out;
  int fails = 0;
  int n_tests = 0;
  assign f_dq_in = f_dq_oe ? f_dq_out : model_out;
  fsw_host_ctrl i_fsw_host_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .f_addr(f_addr),
    .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n), .f_dq_out(f_dq_out),
    .f_dq_oe(f_dq_oe), .f_dq_in(f_dq_in), .f_hv_en(f_hv_en));
  fsw_flash_model i_fsw_flash_model (.pclk(pclk), .presetn(presetn), .f_addr(f_addr),
    .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n), .f_hv_en(f_hv_en),
    .bus_in(f_dq_in), .bus_out(model_out));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(n >= 50), 32'h0, "apb answer missing");
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic err;
    apb(1'b1, a, d, q, err);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] q);
    logic err;
    apb(1'b0, a, 32'h0, q, err);
  endtask
  task automatic fop(input logic [2:0] c, input logic [17:0] a, input logic [7:0] d);
    logic [31:0] s;
    int n;
    wr(FSW_REG_ADDR, {14'h0000, a});
    wr(FSW_REG_DATA, {24'h000000, d});
    wr(FSW_REG_CTRL, {29'h00000000, c});
    n = 0;
    do begin
      rdr(FSW_REG_STAT, s);
      n++;
    end while (s[FSW_ST_BUSY] !== 1'b0 && n < 3000);
    check(s[FSW_ST_BUSY], 1'b0, "operation never finished");
  endtask
  task automatic rdb(input logic [17:0] a, output logic [31:0] q);
    fop(FSW_CMD_READ, a, 8'h00);
    rdr(FSW_REG_RDAT, q);
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop;
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    clk_en = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdr(FSW_REG_STAT, v);
    check(v, 32'h0, "status after reset");
    apb(1'b0, 8'h14, 32'h0, v, e);
    check(e, 1'b1, "unmapped address accepted");
    $display("test reset done");
    fop(FSW_CMD_WRITE, 18'h6, 8'h5a);
    rdb(18'h6, v);
    check(v[7:0], 8'hff, "lone write changed the array");
    fop(FSW_CMD_WRITE, 18'h0, 8'ha0);
    fop(FSW_CMD_WRITE, 18'h6, 8'h5a);
    fop(FSW_CMD_POLL, 18'h6, 8'h00);
    rdr(FSW_REG_STAT, v);
    check(v[FSW_ST_DONE], 1'b1, "poll did not finish");
    check(v[FSW_ST_FAIL], 1'b0, "poll reported failure");
    rdb(18'h6, v);
    check(v[7:0], 8'h5a, "array data after poll");
    $display("test program done");
    // Programming a non-blank byte locks the model until a reset command arrives.
    fop(FSW_CMD_WRITE, 18'h0, 8'ha0);
    fop(FSW_CMD_WRITE, 18'h6, 8'h00);
    fop(FSW_CMD_POLL, 18'h6, 8'h00);
    rdr(FSW_REG_STAT, v);
    check(v[FSW_ST_FAIL], 1'b1, "time limit not reported");
    check(i_fsw_flash_model.stuck_r, 1'b0, "reset command not written");
    rdb(18'h6, v);
    check(v[7:0], 8'h5a, "array data after reset");
    $display("test time limit done");
    // A frozen clock enable must stretch the protect pulse past its own length.
    wr(FSW_REG_ADDR, 32'h0);
    wr(FSW_REG_CTRL, {29'h00000000, FSW_CMD_PROT});
    repeat (100) @(posedge pclk);
    clk_en <= 1'b0;
    repeat (FSW_T_PROT_CYC) @(posedge pclk);
    check({f_we_n, f_hv_en}, 2'b01, "pulse not frozen");
    clk_en <= 1'b1;
    // Control writes are ignored while busy, so this call only waits for the pulse end.
    fop(FSW_CMD_PROT, 18'h0, 8'h00);
    fop(FSW_CMD_WRITE, 18'h0, 8'h90);
    fop(FSW_CMD_VERIFY, 18'h0, 8'h00);
    rdr(FSW_REG_RDAT, v);
    check(v[7:0], 8'h01, "protected chip not reported");
    fop(FSW_CMD_WRITE, 18'h0, FSW_CMD_RESET);
    fop(FSW_CMD_WRITE, 18'h0, 8'ha0);
    fop(FSW_CMD_WRITE, 18'h7, 8'h11);
    rdb(18'h7, v);
    check(v[7:0], 8'hff, "protected chip was programmed");
    fop(FSW_CMD_UNPROT, 18'h0, 8'h00);
    fop(FSW_CMD_WRITE, 18'h0, 8'h90);
    fop(FSW_CMD_VERIFY, 18'h0, 8'h00);
    rdr(FSW_REG_RDAT, v);
    check(v[7:0], 8'h00, "unprotected chip not reported");
    fop(FSW_CMD_WRITE, 18'h0, FSW_CMD_RESET);
    $display("test protect done");
    fop(FSW_CMD_WRITE, 18'h4, 8'h80);
    fop(FSW_CMD_WRITE, 18'h4, 8'h30);
    rdb(18'h4, v);
    rdr(FSW_REG_STAT, u);
    check(u[FSW_ST_WINDOW], 1'b0, "window flag high in time-out");
    rdb(18'h8, u);
    rdb(18'h4, w);
    check(u[FSW_BIT_OPTOG], !v[FSW_BIT_OPTOG], "operation toggle bit held");
    check(u[2], 1'b0, "unselected sector toggled");
    check(w[2], !v[2], "selected sector did not toggle");
    fop(FSW_CMD_WRITE, 18'h0, 8'h30);
    rdb(18'h1, u);
    rdb(18'h1, w);
    check(w[2], !u[2], "added sector not accepted");
    fop(FSW_CMD_POLL, 18'h4, 8'h00);
    rdr(FSW_REG_STAT, v);
    check(v[FSW_ST_FAIL], 1'b0, "erase poll failed");
    rdb(18'h6, v);
    check(v[7:0], 8'hff, "sector not erased");
    fop(FSW_CMD_WRITE, 18'h8, 8'h80);
    fop(FSW_CMD_WRITE, 18'h8, 8'h30);
    fop(FSW_CMD_WRITE, 18'h8, 8'h55);
    rdb(18'h8, v);
    check(v[7:0], 8'hff, "time-out kept after other command");
    $display("test erase done");
    report_and_stop;
  end
endmodule
`default_nettype wire
